// *** pwm_regs.vh ***
// register map, field positions, reset values for the three-phase pwm block
`ifndef PWM_REGS_VH
`define PWM_REGS_VH

// register byte offsets (word aligned)
`define OFS_HALF_PERIOD   8'h00
`define OFS_DEAD_TIME     8'h04
`define OFS_MIN_PULSE     8'h08
`define OFS_SYNC_WIDTH    8'h0C
`define OFS_DUTY_A        8'h10
`define OFS_DUTY_B        8'h14
`define OFS_DUTY_C        8'h18
`define OFS_SEGMENT       8'h1C
`define OFS_GATE_CHOP     8'h20
`define OFS_MODE          8'h24
`define OFS_SW_TRIP       8'h28
`define OFS_STATUS        8'h2C
`define OFS_RESTART       8'h30

// reset values
`define RST_HALF_PERIOD   16'h03E8
`define RST_DEAD_TIME     10'h000
`define RST_MIN_PULSE     16'h0000
`define RST_SYNC_WIDTH    8'h27
`define RST_DUTY          16'h01F4
`define RST_SEGMENT       9'h03F
`define RST_GATE_CHOP     10'h000
`define RST_MODE          7'h00

// segment control fields: enables [5:0], crossover [8:6]
`define SEG_EN_AH         0
`define SEG_EN_AL         1
`define SEG_EN_BH         2
`define SEG_EN_BL         3
`define SEG_EN_CH         4
`define SEG_EN_CL         5
`define SEG_XO_A          6
`define SEG_XO_B          7
`define SEG_XO_C          8

// gate chopping fields
`define GATE_FREQ_MSB     7
`define GATE_HI_EN        8
`define GATE_LO_EN        9

// mode control: update mode select
`define MODE_DOUBLE       6

// status fields
`define STAT_TRIP_PIN     0
`define STAT_SHUTDOWN     1
`define STAT_HALF         3

// restart command bit
`define RESTART_GO        0

`endif

// *** three_phase_pwm_generator.v ***
// three-phase center-based pwm generator with apb registers and shutdown
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_regs.vh"

module three_phase_pwm_generator #(
    parameter DT_W = 10   // dead time register width
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // shutdown inputs, asynchronous pins
    input  wire        trip_input_n,
    input  wire [2:0]  current_sense_input,
    // gate drive outputs
    output wire        phase_a_high_drive,
    output wire        phase_a_low_drive,
    output wire        phase_b_high_drive,
    output wire        phase_b_low_drive,
    output wire        phase_c_high_drive,
    output wire        phase_c_low_drive,
    // synchronisation and interrupts
    output reg         period_sync_pulse,
    output reg         sync_irq,
    output reg         trip_irq
);
    // software-visible registers
    reg [15:0]     half_period_ticks;
    reg [DT_W-1:0] dead_time_value;
    reg [15:0]     min_pulse_width;
    reg [7:0]      sync_pulse_width;
    reg [15:0]     duty_phase_a;
    reg [15:0]     duty_phase_b;
    reg [15:0]     duty_phase_c;
    reg [8:0]      output_segment_control;
    reg [9:0]      gate_chopping_control;
    reg [6:0]      mode_control;
    // shadow copies used by the timing and output units
    reg [15:0]     sh_tm;
    reg [DT_W-1:0] sh_dt;
    reg [15:0]     sh_pd;
    reg [15:0]     sh_da;
    reg [15:0]     sh_db;
    reg [15:0]     sh_dc;
    reg [8:0]      sh_seg;
    // timing unit state
    reg [15:0]     tick_cnt;                // up/down tick counter
    reg            count_down;              // high in second half
    reg [7:0]      sync_left;               // ticks of sync pulse left
    reg [7:0]      chop_cnt;                // chopping divider
    reg            chop_phase;              // chopping square wave
    reg [5:0]      drive_q;                 // registered drives
    // shutdown state
    reg            trip_meta;               // pin synchroniser stage 1
    reg            trip_sync;               // pin synchroniser stage 2
    reg [2:0]      oc_meta;                 // overcurrent stage 1
    reg [2:0]      oc_sync;                 // overcurrent stage 2
    reg            shutdown;                // latched shutdown
    reg            shutdown_d;              // for shutdown edge
    // apb decode
    wire           apb_setup = psel & ~penable;
    wire           apb_write = psel & penable & pwrite;
    wire           sw_trip_wr;
    wire           restart_wr;
    reg            addr_ok;
    reg [31:0]     next_prdata;
    // zero-wait slave: the read word is prepared in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign sw_trip_wr = apb_write & (paddr == `OFS_SW_TRIP);
    assign restart_wr = apb_write & (paddr == `OFS_RESTART)
                        & pwdata[`RESTART_GO];
    // center-based on test with dead time and minimum pulse width
    function drive_on;
        input [15:0]     c;
        input [15:0]     tm;
        input [15:0]     duty;
        input [DT_W-1:0] dt;
        input [15:0]     pd;
        input            high_side;
        reg   [17:0]     width;
        reg   [17:0]     lhs;
        reg   [17:0]     rhs;
        begin
            width = 18'h00000;
            lhs   = 18'h00000;
            rhs   = 18'h00000;
            drive_on = 1'b0;
            if (high_side)
            begin
                // on while c >= tm - duty + dt, i.e. c + duty >= tm + dt
                if ({2'b00, duty} > {{(18-DT_W){1'b0}}, dt})
                begin
                    width = {2'b00, duty} - {{(18-DT_W){1'b0}}, dt};
                    lhs   = {2'b00, c} + {2'b00, duty};
                    rhs   = {2'b00, tm} + {{(18-DT_W){1'b0}}, dt};
                    drive_on = (width >= {2'b00, pd}) && (lhs >= rhs);
                end
            end
            else
            begin
                // on while c + duty + dt < tm
                lhs = {2'b00, duty} + {{(18-DT_W){1'b0}}, dt};
                if ({2'b00, tm} > lhs)
                begin
                    width = {2'b00, tm} - lhs;
                    lhs   = lhs + {2'b00, c};
                    drive_on = (width >= {2'b00, pd})
                               && (lhs < {2'b00, tm});
                end
            end
        end
    endfunction
    // last count of a half period; a zero period acts as one tick
    wire [15:0] top_cnt = (sh_tm == 16'h0000) ? 16'h0000
                                              : sh_tm - 16'h0001;
    // period start: turning from down to up at zero
    wire start_evt = ~shutdown & count_down & (tick_cnt == 16'h0000);
    // midpoint: turning from up to down at the top
    wire mid_evt   = ~shutdown & ~count_down & (tick_cnt == top_cnt);
    // boundaries that emit a sync pulse and reload shadows
    wire double_mode = mode_control[`MODE_DOUBLE];
    wire load_evt  = start_evt | (mid_evt & double_mode);
    // read mux and address check
    always @*
    begin
        addr_ok     = 1'b1;
        next_prdata = 32'h00000000;
        case (paddr)
            `OFS_HALF_PERIOD: next_prdata[15:0]     = half_period_ticks;
            `OFS_DEAD_TIME:   next_prdata[DT_W-1:0] = dead_time_value;
            `OFS_MIN_PULSE:   next_prdata[15:0]     = min_pulse_width;
            `OFS_SYNC_WIDTH:  next_prdata[7:0]      = sync_pulse_width;
            `OFS_DUTY_A:      next_prdata[15:0]     = duty_phase_a;
            `OFS_DUTY_B:      next_prdata[15:0]     = duty_phase_b;
            `OFS_DUTY_C:      next_prdata[15:0]     = duty_phase_c;
            `OFS_SEGMENT:     next_prdata[8:0]  = output_segment_control;
            `OFS_GATE_CHOP:   next_prdata[9:0]  = gate_chopping_control;
            `OFS_MODE:        next_prdata[6:0]  = mode_control;
            `OFS_SW_TRIP:     next_prdata       = 32'h00000000;
            `OFS_RESTART:     next_prdata       = 32'h00000000;
            `OFS_STATUS:
            begin
                next_prdata[`STAT_TRIP_PIN] = trip_sync;
                next_prdata[`STAT_SHUTDOWN] = shutdown;
                next_prdata[`STAT_HALF]     = count_down;
            end
            default:          addr_ok = 1'b0;  // unmapped: slave error
        endcase
    end
    // read data register, loaded in the setup cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (apb_setup && !pwrite)
            prdata <= next_prdata;
    end
    // register writes take effect in the access cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            half_period_ticks      <= `RST_HALF_PERIOD;
            dead_time_value        <= `RST_DEAD_TIME;
            min_pulse_width        <= `RST_MIN_PULSE;
            sync_pulse_width       <= `RST_SYNC_WIDTH;
            duty_phase_a           <= `RST_DUTY;
            duty_phase_b           <= `RST_DUTY;
            duty_phase_c           <= `RST_DUTY;
            output_segment_control <= `RST_SEGMENT;
            gate_chopping_control  <= `RST_GATE_CHOP;
            mode_control           <= `RST_MODE;
        end
        else if (apb_write)
        begin
            case (paddr)
                `OFS_HALF_PERIOD: half_period_ticks <= pwdata[15:0];
                `OFS_DEAD_TIME:   dead_time_value   <= pwdata[DT_W-1:0];
                `OFS_MIN_PULSE:   min_pulse_width   <= pwdata[15:0];
                `OFS_SYNC_WIDTH:  sync_pulse_width  <= pwdata[7:0];
                `OFS_DUTY_A:      duty_phase_a      <= pwdata[15:0];
                `OFS_DUTY_B:      duty_phase_b      <= pwdata[15:0];
                `OFS_DUTY_C:      duty_phase_c      <= pwdata[15:0];
                `OFS_SEGMENT:     output_segment_control <= pwdata[8:0];
                `OFS_GATE_CHOP:   gate_chopping_control  <= pwdata[9:0];
                `OFS_MODE:        mode_control           <= pwdata[6:0];
                default:          mode_control           <= mode_control;
            endcase
        end
    end
    // two-flop synchronisers; stage 1 feeds only stage 2
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trip_meta <= 1'b1;
            trip_sync <= 1'b1;
            oc_meta   <= 3'b000;
            oc_sync   <= 3'b000;
        end
        else
        begin
            trip_meta <= trip_input_n;
            trip_sync <= trip_meta;
            oc_meta   <= current_sense_input;
            oc_sync   <= oc_meta;
        end
    end
    // shutdown latch: a new trip wins over a restart in the same cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shutdown   <= 1'b0;
            shutdown_d <= 1'b0;
            trip_irq   <= 1'b0;
        end
        else
        begin
            if (!trip_sync || (|oc_sync) || sw_trip_wr)
                shutdown <= 1'b1;
            else if (restart_wr)
                shutdown <= 1'b0;
            shutdown_d <= shutdown;
            trip_irq   <= shutdown & ~shutdown_d;
        end
    end
    // timing unit: counter held at zero while shut down, and the
    // shadows reload at every boundary that emits a sync pulse
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt   <= 16'h0000;
            count_down <= 1'b1;
            sh_tm      <= `RST_HALF_PERIOD;
            sh_dt      <= `RST_DEAD_TIME;
            sh_pd      <= `RST_MIN_PULSE;
            sh_da      <= `RST_DUTY;
            sh_db      <= `RST_DUTY;
            sh_dc      <= `RST_DUTY;
            sh_seg     <= `RST_SEGMENT;
        end
        else if (shutdown)
        begin
            tick_cnt   <= 16'h0000;
            count_down <= 1'b1;
        end
        else
        begin
            if (start_evt)
                count_down <= 1'b0;
            else if (mid_evt)
                count_down <= 1'b1;
            else if (count_down)
                tick_cnt <= tick_cnt - 16'h0001;
            else
                tick_cnt <= tick_cnt + 16'h0001;
            if (load_evt)
            begin
                sh_tm  <= half_period_ticks;
                sh_dt  <= dead_time_value;
                sh_pd  <= min_pulse_width;
                sh_da  <= duty_phase_a;
                sh_db  <= duty_phase_b;
                sh_dc  <= duty_phase_c;
                sh_seg <= output_segment_control;
            end
        end
    end
    // sync pulse lasts width+1 ticks from each boundary
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_left         <= 8'h00;
            period_sync_pulse <= 1'b0;
            sync_irq          <= 1'b0;
        end
        else
        begin
            sync_irq <= load_evt;
            if (load_evt)
            begin
                sync_left         <= sync_pulse_width;
                period_sync_pulse <= 1'b1;
            end
            else if (sync_left != 8'h00)
                sync_left <= sync_left - 8'h01;
            else
                period_sync_pulse <= 1'b0;
        end
    end
    // chopping divider: square wave toggles every freq+1 ticks
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chop_cnt   <= 8'h00;
            chop_phase <= 1'b0;
        end
        else if (chop_cnt >= gate_chopping_control[`GATE_FREQ_MSB:0])
        begin
            chop_cnt   <= 8'h00;
            chop_phase <= ~chop_phase;
        end
        else
            chop_cnt <= chop_cnt + 8'h01;
    end
    // raw complementary pairs from the timing unit
    wire raw_ah = drive_on(tick_cnt, sh_tm, sh_da, sh_dt, sh_pd, 1'b1);
    wire raw_al = drive_on(tick_cnt, sh_tm, sh_da, sh_dt, sh_pd, 1'b0);
    wire raw_bh = drive_on(tick_cnt, sh_tm, sh_db, sh_dt, sh_pd, 1'b1);
    wire raw_bl = drive_on(tick_cnt, sh_tm, sh_db, sh_dt, sh_pd, 1'b0);
    wire raw_ch = drive_on(tick_cnt, sh_tm, sh_dc, sh_dt, sh_pd, 1'b1);
    wire raw_cl = drive_on(tick_cnt, sh_tm, sh_dc, sh_dt, sh_pd, 1'b0);
    // output control: crossover, per-output enable, then chopping
    wire xo_ah = sh_seg[`SEG_XO_A] ? raw_al : raw_ah;
    wire xo_al = sh_seg[`SEG_XO_A] ? raw_ah : raw_al;
    wire xo_bh = sh_seg[`SEG_XO_B] ? raw_bl : raw_bh;
    wire xo_bl = sh_seg[`SEG_XO_B] ? raw_bh : raw_bl;
    wire xo_ch = sh_seg[`SEG_XO_C] ? raw_cl : raw_ch;
    wire xo_cl = sh_seg[`SEG_XO_C] ? raw_ch : raw_cl;
    // chop mask per side; a disabled side passes unchanged
    wire chop_hi = ~gate_chopping_control[`GATE_HI_EN] | chop_phase;
    wire chop_lo = ~gate_chopping_control[`GATE_LO_EN] | chop_phase;
    // registered drives; the drives are cleared while shut down
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            drive_q <= 6'b000000;
        else if (shutdown)
            drive_q <= 6'b000000;
        else
        begin
            drive_q[0] <= xo_ah & sh_seg[`SEG_EN_AH] & chop_hi;
            drive_q[1] <= xo_al & sh_seg[`SEG_EN_AL] & chop_lo;
            drive_q[2] <= xo_bh & sh_seg[`SEG_EN_BH] & chop_hi;
            drive_q[3] <= xo_bl & sh_seg[`SEG_EN_BL] & chop_lo;
            drive_q[4] <= xo_ch & sh_seg[`SEG_EN_CH] & chop_hi;
            drive_q[5] <= xo_cl & sh_seg[`SEG_EN_CL] & chop_lo;
        end
    end
    // unclocked kill path: pins gate the drives even with no clock,
    // at the cost of a combinational path from pins to outputs
    wire hw_ok = trip_input_n & ~(|current_sense_input);
    // six gate drive outputs, off means low
    assign phase_a_high_drive = drive_q[0] & hw_ok;
    assign phase_a_low_drive  = drive_q[1] & hw_ok;
    assign phase_b_high_drive = drive_q[2] & hw_ok;
    assign phase_b_low_drive  = drive_q[3] & hw_ok;
    assign phase_c_high_drive = drive_q[4] & hw_ok;
    assign phase_c_low_drive  = drive_q[5] & hw_ok;
endmodule
`default_nettype wire

// *** three_phase_pwm_generator_checker.sv ***
// port checker for the three-phase pwm generator, bound into the design
`timescale 1ns/1ns
`default_nettype none
module pwm_port_checker #(
    parameter DT_W = 10
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // trip pins
    input wire logic        trip_input_n,
    input wire logic [2:0]  current_sense_input,
    // drives and events
    input wire logic        phase_a_high_drive,
    input wire logic        phase_a_low_drive,
    input wire logic        phase_b_high_drive,
    input wire logic        phase_b_low_drive,
    input wire logic        phase_c_high_drive,
    input wire logic        phase_c_low_drive,
    input wire logic        period_sync_pulse,
    input wire logic        sync_irq,
    input wire logic        trip_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // all six drives as one word
    wire [5:0] drv = {phase_c_low_drive, phase_c_high_drive,
        phase_b_low_drive, phase_b_high_drive,
        phase_a_low_drive, phase_a_high_drive};
    // any hardware trip source active
    wire hw_trip = !trip_input_n || (|current_sense_input);
    // software trip write taken at this edge
    wire sw_wr = psel && penable && pwrite && paddr == 8'h28;
    logic [7:0] wid;     // mirror of the sync width register
    logic [7:0] wid_at;  // width in force for the current pulse
    logic [8:0] hi_n;    // high cycles of the current pulse
    // mirror kept from bus writes; width frozen at the first high sample
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wid <= 8'h27;
            wid_at <= 8'h27;
            hi_n <= 9'h000;
        end
        else
        begin
            if (psel && penable && pwrite && paddr == 8'h0C)
                wid <= pwdata[7:0];
            if (period_sync_pulse && hi_n == 9'h000)
                wid_at <= wid;
            hi_n <= period_sync_pulse ? hi_n + 9'h001 : 9'h000;
        end
    end
    a_pin_trip_off: assert property (!trip_input_n |-> drv == 6'h00)
        else $error("drive on while trip pin low");
    a_sense_trip_off: assert property (|current_sense_input |-> drv == 6'h00)
        else $error("drive on while current sense trips");
    a_pair_exclusive: assert property (!(drv[0] && drv[1]) &&
        !(drv[2] && drv[3]) && !(drv[4] && drv[5]))
        else $error("both switches of one leg on");
    a_sync_width_exact: assert property ($fell(period_sync_pulse) |->
        hi_n == {1'h0, wid_at} + 9'h001)
        else $error("sync pulse width wrong");
    a_sync_irq_follow: assert property ($rose(period_sync_pulse) |->
        ##[0:1] sync_irq)
        else $error("no sync interrupt after sync pulse");
    a_trip_irq_pulse: assert property (trip_irq |=> !trip_irq)
        else $error("trip interrupt longer than one cycle");
    a_sw_trip_off: assert property (sw_wr |-> ##[1:3] drv == 6'h00)
        else $error("software trip left drives on");
    a_sw_trip_irq: assert property (sw_wr |-> ##[1:3] trip_irq)
        else $error("no interrupt on software trip");
    a_hw_trip_irq: assert property ($rose(hw_trip) |-> ##[1:8] trip_irq)
        else $error("no interrupt on hardware trip");
    a_unmapped_err: assert property (psel && penable && paddr > 8'h30
        |-> pslverr)
        else $error("unmapped access without slave error");
    cover property ($rose(period_sync_pulse));
    cover property (sw_wr);
    cover property ($rose(hw_trip));
endmodule
bind three_phase_pwm_generator pwm_port_checker #(.DT_W(DT_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .trip_input_n(trip_input_n),
    .current_sense_input(current_sense_input),
    .phase_a_high_drive(phase_a_high_drive),
    .phase_a_low_drive(phase_a_low_drive),
    .phase_b_high_drive(phase_b_high_drive),
    .phase_b_low_drive(phase_b_low_drive),
    .phase_c_high_drive(phase_c_high_drive),
    .phase_c_low_drive(phase_c_low_drive),
    .period_sync_pulse(period_sync_pulse), .sync_irq(sync_irq),
    .trip_irq(trip_irq));
`default_nettype wire

// *** gate_driver_model.sv ***
// inverter gate driver model: watches the legs, raises a fault on demand
`timescale 1ns/1ns
`default_nettype none
module gate_driver_model (
    // clock
    input wire logic       pclk,
    // six drives, pairs as bits 1:0, 3:2, 5:4
    input wire logic [5:0] drv,
    // fault request from the bench
    input wire logic       fault_req,
    // fault line and shoot-through flag
    output logic           trip_input_n,
    output logic           shoot_seen
);
    // a desaturation fault pulls the trip line low at once
    assign trip_input_n = !fault_req;
    // both switches of a leg on together would short the dc link
    initial shoot_seen = 1'h0;
    always @(posedge pclk)
    begin
        if ((drv[0] & drv[1]) | (drv[2] & drv[3]) | (drv[4] & drv[5]))
            shoot_seen <= 1'h1;
    end
endmodule
`default_nettype wire

// *** tb_three_phase_pwm_generator.sv ***
// self-checking bench for the three-phase pwm generator
`timescale 1ns/1ns
`default_nettype none
module tb_three_phase_pwm_generator;
    typedef struct {
        logic [31:0] seg;
        logic [31:0] gate;
        logic [31:0] dt;
        int          ah;
        int          al;
        int          cl;
    } row_t;
    logic        pclk = 1'h0;         // bus clock
    logic        presetn = 1'h0;      // async reset
    logic        psel = 1'h0;         // apb request
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        fault_req = 1'h0;    // gate driver fault
    logic [2:0]  sense = 3'h0;        // overcurrent trips
    wire         pready;
    wire  [31:0] prdata;
    wire         pslverr;
    wire         trip_n;
    wire         sync;
    wire         shoot;
    wire  [5:0]  drv;
    int          fails = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          len;                 // measured period or busy count
    logic [31:0] sw;                  // measured sync width
    logic [31:0] on [6];              // on-cycles of each drive
    logic [31:0] r;                   // last read data
    logic [31:0] s;                   // saved status
    logic        e;                   // last slave error
    logic [31:0] rstv [10] = '{32'h3E8, 32'h0, 32'h0, 32'h27, 32'h1F4,
        32'h1F4, 32'h1F4, 32'h3F, 32'h0, 32'h0};
    logic [31:0] msk [10] = '{32'hFFFF, 32'h3FF, 32'hFFFF, 32'hFF,
        32'hFFFF, 32'hFFFF, 32'hFFFF, 32'h1FF, 32'h3FF, 32'h7F};
    // dead time, crossover, enables, chopping; base case last
    row_t rows [5] = '{'{32'h3F, 32'h0, 32'h1, 2, 10, 2},
        '{32'h5F, 32'h0, 32'h0, 12, 4, 0},
        '{32'h3F, 32'h100, 32'h0, 2, 12, 4},
        '{32'h3F, 32'h200, 32'h0, 4, 6, 2},
        '{32'h3F, 32'h0, 32'h0, 4, 12, 4}};
    three_phase_pwm_generator u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .trip_input_n(trip_n),
        .current_sense_input(sense), .phase_a_high_drive(drv[0]),
        .phase_a_low_drive(drv[1]), .phase_b_high_drive(drv[2]),
        .phase_b_low_drive(drv[3]), .phase_c_high_drive(drv[4]),
        .phase_c_low_drive(drv[5]), .period_sync_pulse(sync),
        .sync_irq(), .trip_irq());
    gate_driver_model u_gdm (.pclk(pclk), .drv(drv),
        .fault_req(fault_req), .trip_input_n(trip_n), .shoot_seen(shoot));
    // 100 MHz clock
    always #5 pclk = ~pclk;
    // hang guard, well above the expected run length
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails = fails + 1;
            tally_and_finish;
        end
    end
    // verdict and end of run
    task automatic tally_and_finish;
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // wait for the next rising sync pulse, with no time limit of its own
    task automatic next_rise;
        do @(negedge pclk); while (sync !== 1'h0);
        do @(negedge pclk); while (sync !== 1'h1);
    endtask
    // skip to the second sync pulse so new shadows settle, then time the span to the next sync pulse
    task automatic measure;
        len = 0;
        sw = 0;
        on = '{default: 0};
        next_rise;
        next_rise;
        do
        begin
            len++;
            sw += sync;
            for (int i = 0; i < 6; i++) on[i] += drv[i];
            @(negedge pclk);
        end while (!(sync === 1'h1 && len > sw) && len < 5000);
    endtask
    // count cycles with any drive or sync active
    task automatic quiet(input int k);
        len = 0;
        repeat (k)
        begin
            @(negedge pclk);
            if (drv !== 6'h00 || sync !== 1'h0) len++;
        end
    endtask
    // main sequence
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        // reset values and writable widths, all done inside the first period
        for (int i = 0; i < 10; i++)
        begin
            apb(1'h0, 8'(i * 4), 32'h0);
            check(r, rstv[i]);
            apb(1'h1, 8'(i * 4), 32'hFFFFFFFF);
            apb(1'h0, 8'(i * 4), 32'h0);
            check(r, msk[i]);
        end
        apb(1'h0, 8'h34, 32'h0);
        check(r, 32'h0);
        check(e, 1'h1);
        apb(1'h1, 8'h00, 32'h8);
        apb(1'h1, 8'h08, 32'h0);
        apb(1'h1, 8'h0C, 32'h2);
        apb(1'h1, 8'h10, 32'h2);
        apb(1'h1, 8'h14, 32'h4);
        apb(1'h1, 8'h18, 32'h6);
        apb(1'h1, 8'h24, 32'h0);
        // half period of 8 ticks: full period 16, sync 3 wide
        foreach (rows[k])
        begin
            apb(1'h1, 8'h04, rows[k].dt);
            apb(1'h1, 8'h1C, rows[k].seg);
            apb(1'h1, 8'h20, rows[k].gate);
            measure;
            check(len, 16);
            check(sw, 3);
            check(on[0], rows[k].ah);
            check(on[1], rows[k].al);
            check(on[5], rows[k].cl);
        end
        // double update: a pulse at each half, status half flag flips
        apb(1'h1, 8'h24, 32'h40);
        measure;
        check(len, 8);
        next_rise;
        apb(1'h0, 8'h2C, 32'h0);
        s = r;
        next_rise;
        apb(1'h0, 8'h2C, 32'h0);
        check(r[3] ^ s[3], 1'h1);
        check(r[0], 1'h1);
        apb(1'h1, 8'h24, 32'h0);
        // trip by fault pin, by current sense, by software write
        for (int k = 0; k < 3; k++)
        begin
            next_rise;
            repeat (5) @(posedge pclk);
            if (k == 0) fault_req <= 1'h1;
            if (k == 1) sense <= 3'h4;
            if (k == 2) apb(1'h1, 8'h28, 32'h1);
            repeat (k < 2 ? 1 : 3) @(negedge pclk);
            check({26'h0, drv}, 32'h0);
            @(posedge pclk);
            fault_req <= 1'h0;
            sense <= 3'h0;
            repeat (5) @(posedge pclk);
            apb(1'h0, 8'h2C, 32'h0);
            check(r[1], 1'h1);
            quiet(40);
            check(len, 0);
            apb(1'h1, 8'h30, 32'h1);
            measure;
            check(len, 16);
            check(on[1], 12);
        end
        check(shoot, 1'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
